// ===== pfp_buf2.sv
// Purpose: two-entry valid/ready buffer for read data
// Assumes: single clock, async active-low reset
// Notes:   full at two entries, so a stalled reader never loses a word
`timescale 1ns/10ps
module pfp_buf2
(
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// fill side
	input  wire logic                      in_valid,
	output logic                           in_ready,
	input  wire logic [pfp_pkg::DATA_W-1:0] in_data,
	// drain side
	output logic                           out_valid,
	input  wire logic                      out_ready,
	output logic      [pfp_pkg::DATA_W-1:0] out_data
);
	import pfp_pkg::*;
	logic [DATA_W-1:0] mem [2];
	logic              wr_ptr;
	logic              rd_ptr;
	logic [1:0]        count;
	wire               push = in_valid && in_ready;
	wire               pop  = out_valid && out_ready;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
			mem[0] <= DATA_RESET;
			mem[1] <= DATA_RESET;
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ===== pfp_flash_model.sv
// Purpose: behavioural parallel page flash
// Assumes: strobes active low, no lock or erase codes
// Notes:   released pins show the inverse of the last value
`timescale 1ns/10ps
module pfp_flash_model
#(
	parameter int TWC_NS   = 20000,
	parameter int TLOAD_NS = 150000
)
(
	// strobes and address
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic [14:0] addr,
	// data pins
	input wire logic [7:0]  dq_in,
	output logic     [7:0]  dq_out
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  pg [0:63];
	logic [63:0] ld = '0;
	logic [14:0] la;
	logic [7:0]  lastd;
	logic        busy = 0;
	logic        tgl = 0;
	logic        armed = 0;
	// lock and erase codes are not decoded; lock stays as delivered
	logic        locked = 0;
	realtime     tr;
	wire         st = ce_n | we_n | ~oe_n;
	initial foreach (mem[i]) mem[i] = 8'hff;
	// a load needs a real fall first, so the power-up rise loads nothing
	always @(negedge st)
	begin
		la = addr;
		armed = 1;
	end
	always @(posedge st) if (!busy && armed)
	begin
		armed = 0;
		pg[la[5:0]] = dq_in;
		ld[la[5:0]] = 1'b1;
		lastd = dq_in;
		tr = $realtime;
		fork
			begin
				#(TLOAD_NS);
				// only the last load's timer may close the page
				if ($realtime - tr >= TLOAD_NS && !busy)
				begin
					busy = 1;
					for (int i = 0; i < 64; i++)
						if (!locked)
							mem[{la[14:6], i[5:0]}] = ld[i] ? pg[i] : 8'hff;
					ld = '0;
					#(TWC_NS) busy = 0;
				end
			end
		join_none
	end
	always @(negedge oe_n) if (busy) tgl = ~tgl;
	always @(ce_n, oe_n, we_n, addr, busy, tgl)
		if (!ce_n && !oe_n && we_n)
			dq_out = busy ? {~lastd[7], tgl, lastd[5:0]} : mem[addr];
		else
			dq_out = ~dq_out;
endmodule

// ===== pfp_host.sv
// Purpose: host controller driving a parallel page flash over its pins
// Assumes: flash strobes are active low; one command at a time
// Notes:   writes are single byte loads; the caller streams a page
`timescale 1ns/10ps
module pfp_host
(
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// command: write or read one byte
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire logic                        cmd_write,
	input  wire logic                        cmd_last,
	input  wire logic [pfp_pkg::ADDR_W-1:0]  cmd_addr,
	input  wire logic [pfp_pkg::DATA_W-1:0]  cmd_data,
	// read data stream
	output logic                             rd_valid,
	input  wire logic                        rd_ready,
	output logic      [pfp_pkg::DATA_W-1:0]  rd_data,
	// status
	output logic                             busy,
	output logic                             load_timeout,
	// flash pins
	output logic                             flash_ce_n,
	output logic                             flash_oe_n,
	output logic                             flash_we_n,
	output logic      [pfp_pkg::ADDR_W-1:0]  flash_addr,
	input  wire logic [pfp_pkg::DATA_W-1:0]  flash_dq_in,
	output logic      [pfp_pkg::DATA_W-1:0]  flash_dq_out,
	output logic                             flash_dq_oe
);
	import pfp_pkg::*;

	// ------------------------------------------------------------
	// state and registers
	// ------------------------------------------------------------
	pfp_state_e        state;
	pfp_state_e        next_state;
	logic [CNT_W-1:0]  cnt;
	logic [CNT_W-1:0]  gap;
	logic              loading;
	logic [DATA_W-1:0] dq_s1;
	logic [DATA_W-1:0] dq_s2;
	logic [DATA_W-1:0] dq_s3;
	logic [DATA_W-1:0] last_data;
	logic [DATA_W-1:0] prev_poll;
	logic              poll_seen;
	logic              last_flag;
	logic              buf_in_valid;
	logic [DATA_W-1:0] buf_in_data;
	logic              buf_in_ready;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// a change counts once the second and third stages agree
	wire               dq_stable = (dq_s2 == dq_s3);
	wire               cnt_done  = (cnt == '0);
	wire               take_cmd  = cmd_valid && cmd_ready;
	// poll done when true data returns and the toggle bit stops
	wire               poll_done = poll_seen && dq_stable
		&& (dq_s3[POLL_BIT] == last_data[POLL_BIT])
		&& (dq_s3[TOGGLE_BIT] == prev_poll[TOGGLE_BIT]);
	wire               gap_over  = (gap >= CNT_W'(LOAD_TIMEOUT_CYC - 8));
	wire               in_load   = (state == PFP_WLOW) || (state == PFP_WHIGH);
	wire               in_read   = (state == PFP_RSET) || (state == PFP_RWAIT)
		|| (state == PFP_POLL) || (state == PFP_PWAIT);
	// oe rises between polls so every poll is a fresh read
	wire               poll_gap  = (state == PFP_PWAIT)
		&& (next_state == PFP_POLL);

	// reads wait for the page to finish; no load once the gap ran out
	assign cmd_ready = (state == PFP_IDLE) && buf_in_ready
		&& !(loading && (gap_over || !cmd_write));

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			PFP_IDLE:
				if (take_cmd)
					next_state = cmd_write ? PFP_WLOW : PFP_RSET;
				else if (loading && gap_over)
					next_state = PFP_POLL;
			PFP_RSET:
				if (cnt_done)
					next_state = PFP_RWAIT;
			PFP_RWAIT:
				next_state = PFP_IDLE;
			PFP_WLOW:
				if (cnt_done)
					next_state = PFP_WHIGH;
			PFP_WHIGH:
				if (cnt_done)
					next_state = last_flag ? PFP_POLL : PFP_IDLE;
			PFP_POLL:
				if (cnt_done)
					next_state = PFP_PWAIT;
			PFP_PWAIT:
				next_state = poll_done ? PFP_IDLE : PFP_POLL;
			default:
				next_state = PFP_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state     <= PFP_IDLE;
			cnt       <= '0;
			gap       <= '0;
			loading   <= 1'b0;
			last_data <= DATA_RESET;
			prev_poll <= DATA_RESET;
			poll_seen <= 1'b0;
			last_flag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (next_state != state)
				cnt <= (next_state == PFP_WHIGH) ? CNT_W'(STROBE_HIGH_CYC - 1)
				: (next_state == PFP_WLOW) ? CNT_W'(STROBE_LOW_CYC - 1)
				: CNT_W'(READ_ACCESS_CYC + 1);
			else if (!cnt_done)
				cnt <= cnt - 1'b1;
			// gap since the last PFP_WHIGH of the load phase ended
			if (in_load)
				gap <= '0;
			else if (loading && !gap_over)
				gap <= gap + 1'b1;
			if (take_cmd && cmd_write)
			begin
				last_data <= cmd_data;
				last_flag <= cmd_last;
				loading   <= 1'b1;
			end
			else if (next_state == PFP_POLL)
				loading <= 1'b0;
			if (state == PFP_PWAIT)
			begin
				prev_poll <= dq_s3;
				poll_seen <= 1'b1;
			end
			else if (state == PFP_IDLE)
				poll_seen <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// pins and data path
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_ce_n   <= RESET_STROBES[0];
			flash_oe_n   <= RESET_STROBES[1];
			flash_we_n   <= RESET_STROBES[2];
			flash_addr   <= '0;
			flash_dq_out <= DATA_RESET;
			flash_dq_oe  <= 1'b0;
			dq_s1        <= DATA_RESET;
			dq_s2        <= DATA_RESET;
			dq_s3        <= DATA_RESET;
			busy         <= 1'b0;
			load_timeout <= 1'b0;
		end
		else
		begin
			dq_s1 <= flash_dq_in;
			dq_s2 <= dq_s1;
			dq_s3 <= dq_s2;
			// address held across the strobe; page bits stable on fall
			if (take_cmd)
				flash_addr <= cmd_addr;
			if (take_cmd && cmd_write)
				flash_dq_out <= cmd_data;
			// oe high through the whole load, ce/we fall together
			flash_we_n  <= (next_state != PFP_WLOW);
			flash_ce_n  <= !(next_state == PFP_WLOW || (next_state != PFP_IDLE
				&& next_state != PFP_WHIGH && in_read | (next_state == PFP_RSET)
				| (next_state == PFP_POLL)));
			flash_oe_n  <= poll_gap || !(next_state == PFP_RSET
				|| next_state == PFP_RWAIT || next_state == PFP_POLL
				|| next_state == PFP_PWAIT);
			flash_dq_oe <= (next_state == PFP_WLOW) || (next_state == PFP_WHIGH);
			busy        <= loading || (next_state == PFP_POLL)
				|| (next_state == PFP_PWAIT);
			// one pulse, on the edge that closes the load phase
			load_timeout <= (state == PFP_IDLE) && loading && gap_over;
		end
	end

	// read result enters the buffer only for plain reads
	assign buf_in_valid = (state == PFP_RWAIT);
	assign buf_in_data  = dq_s3;

	pfp_buf2 u_buf
	(
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);
endmodule

// ===== pfp_host_chk_assertions.sv
// Purpose: pin timing checks on the flash host controller
// Assumes: bound to pfp_host, one clock domain
// Notes:   pulse counts follow the strobe walk of the controller
`timescale 1ns/10ps
module pfp_host_chk
(
	// host side
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic                       cmd_valid,
	input wire logic                       cmd_ready,
	input wire logic                       cmd_write,
	input wire logic                       rd_valid,
	input wire logic                       rd_ready,
	input wire logic [pfp_pkg::DATA_W-1:0] rd_data,
	input wire logic                       load_timeout,
	// flash pins
	input wire logic                       flash_ce_n,
	input wire logic                       flash_oe_n,
	input wire logic                       flash_we_n,
	input wire logic [pfp_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [pfp_pkg::DATA_W-1:0] flash_dq_out,
	input wire logic                       flash_dq_oe
);
	import pfp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ---
	// strobe shapes
	// ---
	sequence s_wlow;
		(!flash_we_n)[*4] ##1 flash_we_n;
	endsequence
	sequence s_whigh;
		flash_we_n[*2];
	endsequence
	a_we_only: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
		else $error("write strobe without chip enable or with oe low");
	a_dq_write: assert property (flash_dq_oe |-> flash_oe_n)
		else $error("data driven while flash may drive");
	a_we_pulse: assert property ($fell(flash_we_n) |-> s_wlow)
		else $error("write strobe low time wrong");
	a_we_gap: assert property ($rose(flash_we_n) |-> s_whigh)
		else $error("write strobe high time too short");
	a_addr_held: assert property (!flash_we_n && $past(!flash_we_n)
		|-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved during strobe");
	a_write_go: assert property (cmd_valid && cmd_ready && cmd_write
		|-> ##[1:2] !flash_we_n && flash_dq_oe)
		else $error("write not started");
	a_read_go: assert property (cmd_valid && cmd_ready && !cmd_write
		|-> ##[1:2] !flash_oe_n && !flash_ce_n && flash_we_n)
		else $error("read not started");
	a_rd_hold: assert property (rd_valid && !rd_ready
		|=> rd_valid && $stable(rd_data))
		else $error("read word lost under stall");
	a_late_load: assert property (load_timeout |-> flash_we_n)
		else $error("byte load after load timeout");
endmodule
bind pfp_host pfp_host_chk u_pfp_host_chk (.clk(clk), .rst_n(rst_n),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
	.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
	.load_timeout(load_timeout), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
	.flash_dq_oe(flash_dq_oe));

// ===== pfp_pkg.sv
// Purpose: constants for the page flash host controller
// Assumes: 40 MHz clock, 32K x 8 parallel flash with 64-byte pages
// Notes:   times in ns, cycle counts derived from the clock period
package pfp_pkg;
	localparam int CLK_PERIOD_NS      = 25;
	localparam int ADDR_W             = 15;
	localparam int DATA_W             = 8;
	localparam int PAGE_BYTES         = 64;
	localparam int BYTE_SEL_W         = 6;
	// strobe timing chosen for a 90 ns class part
	localparam int STROBE_LOW_NS      = 100;
	localparam int STROBE_HIGH_NS     = 50;
	localparam int READ_ACCESS_NS     = 100;
	localparam int LOAD_TIMEOUT_NS    = 150000;
	localparam int STROBE_LOW_CYC     =
		(STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC    =
		(STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_CYC    =
		(READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest allowed gap rounds down
	localparam int LOAD_TIMEOUT_CYC   = LOAD_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int CNT_W              = 16;
	localparam logic [2:0] RESET_STROBES = 3'h7;
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam int POLL_BIT           = 7;
	localparam int TOGGLE_BIT         = 6;

	typedef enum logic [2:0]
	{
		PFP_IDLE  = 3'b000,
		PFP_RSET  = 3'b001,
		PFP_RWAIT = 3'b010,
		PFP_WLOW  = 3'b011,
		PFP_WHIGH = 3'b100,
		PFP_POLL  = 3'b101,
		PFP_PWAIT = 3'b110
	} pfp_state_e;
endpackage

// ===== tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model behind the pins, reference array in the bench
// Notes:   top data bit is flipped so stale array data never ends a poll
`timescale 1ns/10ps
module tb;
	import pfp_pkg::*;
	logic clk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, cmd_last = 0;
	logic rd_ready = 1, saw_to = 0;
	logic [ADDR_W-1:0] cmd_addr = '0, f_addr;
	logic [DATA_W-1:0] cmd_data = '0, rd_data, dq_out, fl_q;
	logic cmd_ready, rd_valid, busy, load_timeout, ce_n, oe_n, we_n, dq_oe;
	wire [DATA_W-1:0] dq_bus = dq_oe ? dq_out : fl_q;
	int errors = 0, tests_run = 0, seed = 20;
	int ref_mem [int];
	logic [7:0] got [$];
	always #12.5 clk = ~clk;
	pfp_host u_pfp_host (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_last(cmd_last),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
		.load_timeout(load_timeout), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
		.flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_in(dq_bus),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
	pfp_flash_model u_pfp_flash_model (.ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(f_addr), .dq_in(dq_bus), .dq_out(fl_q));
	always @(posedge clk)
	begin
		if (rd_valid && rd_ready) got.push_back(rd_data);
		if (load_timeout === 1'b1) saw_to <= 1'b1;
	end
	function automatic logic [7:0] exp_of(input int a);
		return ref_mem.exists(a) ? 8'(ref_mem[a]) : 8'hff;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmd(input logic w, l, input int a, input logic [7:0] d);
		int k;
		k = 0;
		{cmd_valid, cmd_write, cmd_last} = {1'b1, w, l};
		cmd_addr = 15'(a);
		cmd_data = d;
		while (cmd_ready !== 1'b1 && k < 40000)
		begin
			@(posedge clk);
			#2 k++;
		end
		if (k >= 40000) errors++;
		@(posedge clk);
		#2 cmd_valid = 0;
		// one idle edge, so back-to-back calls never rewrite valid at once
		@(posedge clk);
		#2;
	endtask
	task automatic rd_chk(input int a);
		cmd(0, 0, a, 8'h00);
		repeat (40) if (got.size() == 0) @(posedge clk);
		#2 chk(got.size() ? got.pop_front() : 8'hxx, exp_of(a));
	endtask
	task automatic wpage(input int p, n, input logic timed);
		logic [7:0]  d;
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < n; i++)
		begin
			d = 8'($random(seed));
			d[7] = ~exp_of(p * 64 + 63 - 3 * i) >> 7;
			ref_mem[p * 64 + 63 - 3 * i] = d;
			m[63 - 3 * i] = 1'b1;
			cmd(1, !timed && i == n - 1, p * 64 + 63 - 3 * i, d);
		end
		for (int i = 0; i < 64; i++) if (!m[i]) ref_mem.delete(p * 64 + i);
	endtask
	initial
	begin
		#(1_000_000);
		errors++;
		summarize();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		#2 rst_n = 1;
		rd_chk(291);
		// full span, then a sparse rewrite of the same page
		for (int r = 0; r < 2; r++)
		begin
			wpage(5, r ? 7 : 22, 0);
			for (int i = 0; i < 64; i++) rd_chk(320 + i);
		end
		// no last flag: the gap timeout must close the page
		wpage(9, 4, 1);
		chk({7'h00, busy}, 8'h01);
		for (int i = 0; i < 64; i++) rd_chk(576 + i);
		chk({7'h00, saw_to}, 8'h01);
		// stalled reader fills the buffer
		rd_ready = 0;
		cmd(0, 0, 383, 8'h00);
		cmd(0, 0, 380, 8'h00);
		repeat (20) @(posedge clk);
		#2 chk({5'h00, busy, rd_valid, cmd_ready}, 8'h02);
		rd_ready = 1;
		repeat (4) @(posedge clk);
		#2 chk(got.size() ? got.pop_front() : 8'hxx, exp_of(383));
		chk(got.size() ? got.pop_front() : 8'hxx, exp_of(380));
		summarize();
	end
endmodule
